// ### serial_control_and_link_mode_test.sv
// self-checking bench for slm_top with a behavioural register and mode model
// host model drives the bus; pixel clock 125 ns, stopped only to test the pll reset with it enabled and then disabled
`timescale 1ns/1ps
module serial_control_and_link_mode_test;
	import slm_pkg::*;
	localparam int F = 8;
	localparam logic [3:0] OH [4] = '{4'h1, 4'h4, 4'h8, 4'h2};
	logic       clk, nrst, pix, pix_run, scl, sda, scl_l, sda_l, ok;
	logic       scl_o, scl_oe_n, sda_o, sda_oe_n, rx0, rx1, cap;
	logic       tx0, tx1, bc1, spl, half, shr, core1, leg, pll;
	logic [2:0] ast;
	logic [4:0] st;
	wire  [4:0] mir;
	logic [6:0] adr;
	logic [7:0] ctl, cfg, lpc, dq[$], rq[$];
	logic [31:0] seed;
	int         miscompares, tests_run, cyc, pulses;
	assign scl = !scl_l && (scl_oe_n || scl_o);
	assign sda = !sda_l && (sda_oe_n || sda_o);
	slm_top u_dut (.ref_clk_i(clk), .nrst_i(nrst), .pix_clk_i(pix), .scl_i(scl), .scl_o(scl_o),
		.scl_oe_n_o(scl_oe_n), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .address_strap_pin_i(ast),
		.strap_display_id_i(st[4]), .strap_aux_audio_i(st[3]), .strap_external_controller_override_i(st[2]), .strap_cable_i(st[1]),
		.strap_rem_load_i(st[0]), .rx0_present_i(rx0), .rx1_present_i(rx1), .rx_dual_cap_i(cap),
		.tx0_en_o(tx0), .tx1_en_o(tx1), .bc1_en_o(bc1), .pixel_split_o(spl), .tx_half_rate_o(half),
		.prot_shared_o(shr), .prot_core1_en_o(core1), .legacy_compat_o(leg), .pll_rst_o(pll),
		.display_id_disable_o(mir[4]), .aux_audio_o(mir[3]), .ext_override_o(mir[2]), .cable_select_o(mir[1]),
		.remote_display_id_load_o(mir[0]));
	slm_host u_host (.ref_clk_i(clk), .scl_i(scl), .sda_i(sda), .scl_low_o(scl_l), .sda_low_o(sda_l));
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// pixel clock phase unrelated to the reference
	initial
	begin
		pix = 1'b0;
		#17;
		forever #62.5 if (pix_run) pix = ~pix;
	end
	always @(posedge pll) pulses++;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 96000)
		begin
			miscompares++;
			end_sim();
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	function automatic int md();
		if (lpc[4]) return lpc[1:0];
		if (rx0 && cap && F >= 97) return 1;
		if (rx0 && rx1) return 2;
		return rx1 ? 3 : 0;
	endfunction
	function automatic logic [7:0] outs();
		int m;
		m = md();
		return {m != 3, m != 0, !(lpc[4] && m == 0), m == 1, m == 1, m == 1 && cfg[3], m == 2 && cfg[3],
			F < 85 && (m == 0 || m == 3)};
	endfunction
	function automatic logic [7:0] exp_reg(input logic [7:0] a);
		logic [7:0] o;
		o = outs();
		case (a)
			REG_BRIDGE_CONTROL: return ctl;
			REG_BRIDGE_CONFIG:  return cfg;
			REG_LINK_PAIR:      return lpc;
			REG_MODE_STATUS:    return {1'b0, o[0], 2'b00, OH[md()]};
			default:            return 8'h00;
		endcase
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic check_all();
		chk({tx0, tx1, bc1, spl, half, shr, core1, leg}, outs());
		chk(mir, {ctl[0], cfg[1], cfg[7], lpc[7], cfg[5]});
	endtask
	task automatic wrm(input logic [7:0] p);
		u_host.wr(adr, p, dq, ok);
		chk(ok, 1'b1);
		foreach (dq[i])
			case (p + 8'(i))
				REG_BRIDGE_CONTROL: ctl = dq[i];
				REG_BRIDGE_CONFIG:  cfg = dq[i];
				REG_LINK_PAIR:      lpc = dq[i];
				default: ;
			endcase
		repeat (8) @(negedge clk);
		check_all();
	endtask
	task automatic rdc(input logic [7:0] p, input int n);
		logic [7:0] a;
		u_host.rd(adr, p, n, rq, ok);
		chk(ok, 1'b1);
		foreach (rq[i])
		begin
			a = p + 8'(i);
			if (a == REG_FREQ_STATUS)
				chk(rq[i] >= 8'h07 && rq[i] <= 8'h09, 1'b1);
			else
				chk(rq[i], exp_reg(a));
		end
	endtask
	task automatic pll_try(input int exp);
		pulses = 0;
		pix_run = 1'b0;
		repeat (3200) @(negedge clk);
		pix_run = 1'b1;
		repeat (4000) @(negedge clk);
		chk(pulses != 0, exp);
	endtask
	task automatic end_sim();
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		nrst = 1'b0;
		pix_run = 1'b1;
		{rx0, rx1, cap} = 3'b100;
		{miscompares, tests_run, cyc, pulses} = '0;
		seed = xs(32'd84871);
		ast = seed[2:0];
		st = seed[8:4];
		adr = ADDR_BASE + {3'h0, ast, 1'b0};
		ctl = {7'h00, st[4]};
		cfg = {st[2], 1'b0, st[0], 3'h0, st[3], 1'b0};
		lpc = LPC_RST | {st[1], 7'h00};
		repeat (16) @(negedge clk);
		nrst = 1'b1;
		repeat (200) @(negedge clk);
		check_all();
		// straps move after the latch and must not be seen
		st = ~st;
		rdc(REG_BRIDGE_CONTROL, 1);
		dq = {8'h00};
		u_host.wr(adr + 7'h01, REG_LINK_PAIR, dq, ok);
		chk(ok, 1'b0);
		seed = xs(seed);
		dq = {seed[7:0] & 8'hAA | 8'h08};
		wrm(REG_BRIDGE_CONFIG);
		for (int i = 0; i < 4; i++)
		begin
			dq = {lpc & 8'hA0 | 8'h10 | 8'(i)};
			if (i == 0)
				dq.push_back(8'hFF);
			wrm(REG_LINK_PAIR);
		end
		rdc(8'h5A, 4);
		dq = {lpc & 8'hA0 | 8'h20};
		wrm(REG_LINK_PAIR);
		repeat (6)
		begin
			seed = xs(seed);
			{rx0, rx1, cap} = seed[2:0];
			repeat (8) @(negedge clk);
			check_all();
		end
		pll_try(1);
		// host turns the frequency-change reset off after setup
		dq = {lpc & 8'hDF};
		wrm(REG_LINK_PAIR);
		pll_try(0);
		end_sim();
	end
endmodule // serial_control_and_link_mode_test

// ### slm_chk_sva.sv
// checker for bus pin drive and link mode outputs of slm_top
// bound to slm_top below; sees only its ports
`timescale 1ns/1ps
module slm_chk (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic scl_i,
	input wire logic scl_oe_n_o,
	input wire logic sda_o,
	input wire logic sda_oe_n_o,
	input wire logic tx0_en_o,
	input wire logic tx1_en_o,
	input wire logic bc1_en_o,
	input wire logic pixel_split_o,
	input wire logic tx_half_rate_o,
	input wire logic prot_shared_o,
	input wire logic prot_core1_en_o,
	input wire logic legacy_compat_o,
	input wire logic pll_rst_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	// outputs still show reset values at the first edge after release
	logic [1:0] arm_q;
	always_ff @(posedge ref_clk_i)
		arm_q <= nrst_i ? {arm_q[0], 1'b1} : 2'b00;
	default disable iff (!nrst_i || arm_q != 2'b11);
	logic [7:0] hi_q;
	// counts high cycles of the pll reset pulse
	always_ff @(posedge ref_clk_i)
		hi_q <= (!nrst_i || !pll_rst_o) ? 8'h00 : hi_q + 8'h01;
	chk_scl_never_driven: assert property (scl_oe_n_o) else $error("scl driven");
	chk_sda_low_only: assert property (!sda_oe_n_o |-> !sda_o) else $error("sda driven high");
	chk_sda_moves_low: assert property ($changed(sda_oe_n_o) |-> !scl_i) else $error("sda moved with scl high");
	chk_dual_both_links: assert property (pixel_split_o |-> tx0_en_o && tx1_en_o && tx_half_rate_o)
		else $error("dual links wrong");
	chk_split_half_pair: assert property ($changed(pixel_split_o) |-> $changed(tx_half_rate_o))
		else $error("split and rate apart");
	chk_shared_in_dual: assert property (prot_shared_o |-> pixel_split_o && !prot_core1_en_o)
		else $error("shared session outside dual");
	chk_core1_in_repl: assert property (prot_core1_en_o |-> tx0_en_o && tx1_en_o && !pixel_split_o)
		else $error("second core outside replicate");
	chk_bc_off_single: assert property (!bc1_en_o |-> tx0_en_o && !tx1_en_o) else $error("back channel off");
	chk_legacy_one_link: assert property (legacy_compat_o |-> tx0_en_o != tx1_en_o)
		else $error("legacy on two links");
	chk_pll_pulse_len: assert property ($fell(pll_rst_o) |-> hi_q == 8'h14) else $error("pll pulse length");
	cover property ($rose(tx_half_rate_o));
	cover property ($rose(prot_core1_en_o));
	cover property ($rose(pll_rst_o));
	cover property ($fell(sda_oe_n_o));
endmodule // slm_chk

bind slm_top slm_chk u_chk (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .scl_i(scl_i), .scl_oe_n_o(scl_oe_n_o),
	.sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .tx0_en_o(tx0_en_o), .tx1_en_o(tx1_en_o), .bc1_en_o(bc1_en_o),
	.pixel_split_o(pixel_split_o), .tx_half_rate_o(tx_half_rate_o), .prot_shared_o(prot_shared_o),
	.prot_core1_en_o(prot_core1_en_o), .legacy_compat_o(legacy_compat_o), .pll_rst_o(pll_rst_o));

// ### slm_host.sv
// host bus master model for the serial control target
// bench resolves the pulled-up lines from all pull-low requests
`timescale 1ns/1ps
module slm_host (
	input  wire logic ref_clk_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      scl_low_o,
	output logic      sda_low_o
);
	localparam int Q = 50;
	initial
	begin
		scl_low_o = 1'b0;
		sda_low_o = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask
	// lines are only pulled low or let go
	task automatic bit_x(input logic b, output logic r);
		int k;
		k = 0;
		sda_low_o = !b;
		hold(Q);
		scl_low_o = 1'b0;
		while (scl_i !== 1'b1 && k < 4000)
		begin
			hold(1);
			k++;
		end
		hold(Q);
		r = sda_i;
		hold(Q);
		scl_low_o = 1'b1;
		hold(Q);
	endtask
	task automatic start();
		sda_low_o = 1'b0;
		hold(Q);
		scl_low_o = 1'b0;
		hold(Q);
		sda_low_o = 1'b1;
		hold(Q);
		scl_low_o = 1'b1;
		hold(Q);
	endtask
	task automatic stop();
		sda_low_o = 1'b1;
		hold(Q);
		scl_low_o = 1'b0;
		hold(Q);
		sda_low_o = 1'b0;
		hold(2 * Q);
	endtask
	task automatic byte_w(input logic [7:0] d, output logic ok);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], r);
		bit_x(1'b1, r);
		ok = (r === 1'b0);
	endtask
	task automatic byte_r(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_x(1'b1, r);
			d[i] = r;
		end
		bit_x(last, r);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d[$], output logic ok);
		logic o;
		start();
		byte_w({a, 1'b0}, ok);
		if (ok)
		begin
			byte_w(p, o);
			ok &= o;
			foreach (d[i])
			begin
				byte_w(d[i], o);
				ok &= o;
			end
		end
		stop();
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] p, input int n, output logic [7:0] d[$],
		output logic ok);
		logic o;
		logic [7:0] b;
		d = {};
		start();
		byte_w({a, 1'b0}, ok);
		byte_w(p, o);
		ok &= o;
		start();
		byte_w({a, 1'b1}, o);
		ok &= o;
		for (int i = 0; i < n; i++)
		begin
			byte_r(i == n - 1, b);
			d.push_back(b);
		end
		stop();
	endtask
endmodule // slm_host

// ### slm_pkg.sv
// constants for the serial control target and link mode selector
// assumes a 200 MHz reference clock and a pixel clock on its own domain
package slm_pkg;

	// register offsets
	localparam logic [7:0] REG_BRIDGE_CONTROL = 8'h4F;
	localparam logic [7:0] REG_BRIDGE_CONFIG  = 8'h54;
	localparam logic [7:0] REG_LINK_PAIR      = 8'h5B;
	localparam logic [7:0] REG_MODE_STATUS    = 8'h5C;
	localparam logic [7:0] REG_FREQ_STATUS    = 8'h5D;

	// field positions
	localparam int CTL_DISP_ID_DIS = 0;
	localparam int CFG_AUX_AUDIO   = 1;
	localparam int CFG_PROT_EN     = 3;
	localparam int CFG_REM_LOAD    = 5;
	localparam int CFG_EXT_OVR     = 7;
	localparam int LPC_MODE_LO     = 0;
	localparam int LPC_AUTO_DIS    = 4;
	localparam int LPC_PLL_RST     = 5;
	localparam int LPC_CABLE       = 7;

	// reset values; frequency-change reset starts enabled
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] LPC_RST = 8'h20;

	// target address from the address strap
	localparam logic [6:0] ADDR_BASE = 7'h0C;

	// forced mode codes
	localparam logic [1:0] FM_SINGLE = 2'h0;
	localparam logic [1:0] FM_DUAL   = 2'h1;
	localparam logic [1:0] FM_REPL   = 2'h2;
	localparam logic [1:0] FM_SECOND = 2'h3;

	// pixel frequency limits in MHz
	localparam logic [7:0] SINGLE_MAX_MHZ = 8'h60;
	localparam logic [7:0] LEGACY_MAX_MHZ = 8'h55;
	localparam logic [7:0] DUAL_MAX_MHZ   = 8'hAA;
	localparam logic [7:0] REPL_MAX_MHZ   = 8'h55;
	localparam logic [7:0] DUAL_MIN_MHZ   = 8'h61;
	localparam logic [7:0] FREQ_TOL_MHZ   = 8'h02;

	// timing
	localparam int REF_PERIOD_PS = 5000;
	localparam int WIN_NS        = 8000;
	localparam int WIN_CYC       = (WIN_NS * 1000) / REF_PERIOD_PS;
	localparam int PLL_RST_NS    = 100;
	localparam int PLL_RST_CYC   = (PLL_RST_NS * 1000 + REF_PERIOD_PS - 1) / REF_PERIOD_PS;
	localparam logic [2:0] PIX_DIV_LAST = 3'h7;

	typedef enum logic [3:0] {
		MD_SINGLE = 4'b0001,
		MD_SECOND = 4'b0010,
		MD_DUAL   = 4'b0100,
		MD_REPL   = 4'b1000
	} slm_mode_e;

	typedef enum logic [6:0] {
		ST_IDLE = 7'b0000001,
		ST_ADDR = 7'b0000010,
		ST_AACK = 7'b0000100,
		ST_WR   = 7'b0001000,
		ST_WACK = 7'b0010000,
		ST_RD   = 7'b0100000,
		ST_MACK = 7'b1000000
	} slm_state_e;

endpackage

// ### slm_top.sv
// serial control target, strap capture, pixel frequency meter and link mode selector
// assumes external pull-ups on the bus pins and a free-running pixel clock
`timescale 1ns/1ps
module slm_top
	import slm_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       nrst_i,
	input  wire logic       pix_clk_i,
	input  wire logic       scl_i,
	output logic            scl_o,
	output logic            scl_oe_n_o,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_n_o,
	input  wire logic [2:0] address_strap_pin_i,
	input  wire logic       strap_display_id_i,
	input  wire logic       strap_aux_audio_i,
	input  wire logic       strap_external_controller_override_i,
	input  wire logic       strap_cable_i,
	input  wire logic       strap_rem_load_i,
	input  wire logic       rx0_present_i,
	input  wire logic       rx1_present_i,
	input  wire logic       rx_dual_cap_i,
	output logic            tx0_en_o,
	output logic            tx1_en_o,
	output logic            bc1_en_o,
	output logic            pixel_split_o,
	output logic            tx_half_rate_o,
	output logic            prot_shared_o,
	output logic            prot_core1_en_o,
	output logic            legacy_compat_o,
	output logic            pll_rst_o,
	output logic            display_id_disable_o,
	output logic            aux_audio_o,
	output logic            ext_override_o,
	output logic            cable_select_o,
	output logic            remote_display_id_load_o
);
	import slm_pkg::*;

	logic [10:0] win_last;
	logic [4:0]  pll_last;
	assign win_last = 11'(WIN_CYC - 1);
	assign pll_last = 5'(PLL_RST_CYC - 1);

	// pin synchronisers: s1 feeds only s2
	logic [1:0] bus_s1, bus_s2, bus_q;
	logic [7:0] strap_s1, strap_s2;
	logic [2:0] rx_s1, rx_s2;

	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			bus_s1   <= 2'h3;
			bus_s2   <= 2'h3;
			bus_q    <= 2'h3;
			strap_s1 <= 8'h00;
			strap_s2 <= 8'h00;
			rx_s1    <= 3'h0;
			rx_s2    <= 3'h0;
		end
		else
		begin
			bus_s1   <= {scl_i, sda_i};
			bus_s2   <= bus_s1;
			bus_q    <= bus_s2;
			strap_s1 <= {address_strap_pin_i, strap_rem_load_i, strap_cable_i,
				strap_external_controller_override_i, strap_aux_audio_i, strap_display_id_i};
			strap_s2 <= strap_s1;
			rx_s1    <= {rx_dual_cap_i, rx1_present_i, rx0_present_i};
			rx_s2    <= rx_s1;
		end
	end

	logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
	assign scl_s     = bus_s2[1];
	assign sda_s     = bus_s2[0];
	assign scl_rise  = scl_s & ~bus_q[1];
	assign scl_fall  = ~scl_s & bus_q[1];
	assign start_det = scl_s & bus_q[1] & bus_q[0] & ~sda_s;
	assign stop_det  = scl_s & bus_q[1] & ~bus_q[0] & sda_s;

	// register file and strap capture
	logic [7:0] ctl_q, cfg_q, lpc_q;
	logic [6:0] dev_addr_q;
	logic       strap_done_q;
	logic [1:0] strap_cnt_q;
	logic       wr_now;
	logic [7:0] wr_byte, ptr_q;
	logic [7:0] freq_q;
	slm_mode_e  mode_q;
	logic       over_q;

	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			ctl_q        <= CTL_RST;
			cfg_q        <= CFG_RST;
			lpc_q        <= LPC_RST;
			dev_addr_q   <= ADDR_BASE;
			strap_done_q <= 1'b0;
			strap_cnt_q  <= 2'h0;
		end
		else if (!strap_done_q)
		begin
			// waits for the synchronisers to fill before sampling
			strap_cnt_q <= strap_cnt_q + 2'h1;
			if (strap_cnt_q == 2'h3)
			begin
				strap_done_q              <= 1'b1;
				ctl_q[CTL_DISP_ID_DIS]    <= strap_s2[0];
				cfg_q[CFG_AUX_AUDIO]      <= strap_s2[1];
				cfg_q[CFG_EXT_OVR]        <= strap_s2[2];
				lpc_q[LPC_CABLE]          <= strap_s2[3];
				cfg_q[CFG_REM_LOAD]       <= strap_s2[4];
				dev_addr_q <= ADDR_BASE + {3'h0, strap_s2[7:5], 1'b0};
			end
		end
		else if (wr_now)
		begin
			unique case (ptr_q)
				REG_BRIDGE_CONTROL: ctl_q <= wr_byte;
				REG_BRIDGE_CONFIG:  cfg_q <= wr_byte;
				REG_LINK_PAIR:      lpc_q <= wr_byte;
				default: ;
			endcase
		end
	end

	function automatic logic [7:0] reg_read(input logic [7:0] a);
		logic [7:0] r;
		r = 8'h00;
		unique case (a)
			REG_BRIDGE_CONTROL: r = ctl_q;
			REG_BRIDGE_CONFIG:  r = cfg_q;
			REG_LINK_PAIR:      r = lpc_q;
			REG_MODE_STATUS:    r = {pll_rst_o, legacy_compat_o, over_q, 1'b0, mode_q};
			REG_FREQ_STATUS:    r = freq_q;
			default:            r = 8'h00;
		endcase
		return r;
	endfunction

	// serial control target
	slm_state_e st_q;
	logic [2:0] bit_q;
	logic [6:0] sh_q;
	logic [7:0] tx_q, rd_byte;
	logic       ptr_set_q, rd_q, ack_ph_q, nack_q, sda_oe_n_q;

	assign wr_byte = {sh_q, sda_s};
	assign wr_now  = (st_q == ST_WR) & scl_rise & (bit_q == 3'h7) & ptr_set_q;
	// a plain assign would miss register changes that leave the pointer alone
	always_comb
	begin
		rd_byte = reg_read(ptr_q);
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			st_q       <= ST_IDLE;
			bit_q      <= 3'h0;
			sh_q       <= 7'h00;
			tx_q       <= 8'h00;
			ptr_q      <= 8'h00;
			ptr_set_q  <= 1'b0;
			rd_q       <= 1'b0;
			ack_ph_q   <= 1'b0;
			nack_q     <= 1'b0;
			sda_oe_n_q <= 1'b1;
		end
		else if (stop_det)
		begin
			st_q       <= ST_IDLE;
			sda_oe_n_q <= 1'b1;
		end
		else if (start_det && strap_done_q)
		begin
			st_q       <= ST_ADDR;
			bit_q      <= 3'h0;
			ptr_set_q  <= 1'b0;
			ack_ph_q   <= 1'b0;
			sda_oe_n_q <= 1'b1;
		end
		else
		begin
			unique case (st_q)
				ST_IDLE: ;
				ST_ADDR:
					if (scl_rise)
					begin
						sh_q  <= {sh_q[5:0], sda_s};
						bit_q <= bit_q + 3'h1;
						if (bit_q == 3'h7)
						begin
							rd_q <= sda_s;
							st_q <= (sh_q == dev_addr_q) ? ST_AACK : ST_IDLE;
						end
					end
				ST_AACK, ST_WACK:
					if (scl_fall)
					begin
						if (!ack_ph_q)
						begin
							ack_ph_q   <= 1'b1;
							sda_oe_n_q <= 1'b0;
						end
						else if (st_q == ST_AACK && rd_q)
						begin
							ack_ph_q   <= 1'b0;
							st_q       <= ST_RD;
							tx_q       <= rd_byte;
							sda_oe_n_q <= rd_byte[7];
							ptr_q      <= ptr_q + 8'h01;
						end
						else
						begin
							ack_ph_q   <= 1'b0;
							sda_oe_n_q <= 1'b1;
							st_q       <= ST_WR;
						end
					end
				ST_WR:
					if (scl_rise)
					begin
						sh_q  <= {sh_q[5:0], sda_s};
						bit_q <= bit_q + 3'h1;
						if (bit_q == 3'h7)
						begin
							st_q      <= ST_WACK;
							ptr_set_q <= 1'b1;
							ptr_q     <= ptr_set_q ? ptr_q + 8'h01 : wr_byte;
						end
					end
				ST_RD:
				begin
					if (scl_fall)
					begin
						tx_q       <= {tx_q[6:0], 1'b0};
						sda_oe_n_q <= tx_q[6];
					end
					if (scl_rise)
					begin
						bit_q <= bit_q + 3'h1;
						if (bit_q == 3'h7)
							st_q <= ST_MACK;
					end
				end
				ST_MACK:
				begin
					if (scl_rise)
						nack_q <= sda_s;
					if (scl_fall && !ack_ph_q)
					begin
						ack_ph_q   <= 1'b1;
						sda_oe_n_q <= 1'b1;
					end
					else if (scl_fall)
					begin
						ack_ph_q <= 1'b0;
						if (nack_q)
							st_q <= ST_IDLE;
						else
						begin
							st_q       <= ST_RD;
							tx_q       <= rd_byte;
							sda_oe_n_q <= rd_byte[7];
							ptr_q      <= ptr_q + 8'h01;
						end
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// the target never stretches, so the clock line stays released
	always_ff @(posedge ref_clk_i)
	begin
		scl_o      <= 1'b0;
		sda_o      <= 1'b0;
		scl_oe_n_o <= 1'b1;
		sda_oe_n_o <= nrst_i ? sda_oe_n_q : 1'b1;
	end

	// pixel domain: toggle every eight pixel cycles
	logic       prst_s1, prst_s2;
	logic [2:0] pdiv_q;
	logic       ptgl_q;

	always_ff @(posedge pix_clk_i)
	begin
		prst_s1 <= nrst_i;
		prst_s2 <= prst_s1;
	end

	always_ff @(posedge pix_clk_i)
	begin
		if (!prst_s2)
		begin
			pdiv_q <= 3'h0;
			ptgl_q <= 1'b0;
		end
		else
		begin
			pdiv_q <= pdiv_q + 3'h1;
			if (pdiv_q == PIX_DIV_LAST)
				ptgl_q <= ~ptgl_q;
		end
	end

	// one toggle per eight pixel clocks over 8 us reads directly in MHz
	logic        tg_s1, tg_s2, tg_q;
	logic [10:0] win_q;
	logic [7:0]  cnt_q;
	logic        meas_q;

	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			tg_s1  <= 1'b0;
			tg_s2  <= 1'b0;
			tg_q   <= 1'b0;
			win_q  <= 11'h000;
			cnt_q  <= 8'h00;
			freq_q <= 8'h00;
			meas_q <= 1'b0;
		end
		else
		begin
			tg_s1  <= ptgl_q;
			tg_s2  <= tg_s1;
			tg_q   <= tg_s2;
			meas_q <= 1'b0;
			if (win_q == win_last)
			begin
				win_q  <= 11'h000;
				freq_q <= cnt_q;
				cnt_q  <= 8'h00;
				meas_q <= 1'b1;
			end
			else
			begin
				win_q <= win_q + 11'h001;
				if ((tg_s2 ^ tg_q) && cnt_q != 8'hFF)
					cnt_q <= cnt_q + 8'h01;
			end
		end
	end

	// window phase jitter can still trip this; the host turns it off
	logic [7:0] prev_q, fdiff;
	logic [4:0] pcnt_q;
	assign fdiff = (cnt_q > prev_q) ? cnt_q - prev_q : prev_q - cnt_q;

	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			prev_q    <= 8'h00;
			pcnt_q    <= 5'h00;
			pll_rst_o <= 1'b0;
		end
		else
		begin
			if (meas_q)
				prev_q <= freq_q;
			if (win_q == win_last && fdiff > FREQ_TOL_MHZ && lpc_q[LPC_PLL_RST])
			begin
				pll_rst_o <= 1'b1;
				pcnt_q    <= 5'h00;
			end
			else if (pll_rst_o)
			begin
				pcnt_q <= pcnt_q + 5'h01;
				if (pcnt_q == pll_last)
					pll_rst_o <= 1'b0;
			end
		end
	end

	// mode selection
	slm_mode_e mode_d;
	logic      forced_single, prot_en, over_d;
	assign forced_single = lpc_q[LPC_AUTO_DIS] & (lpc_q[LPC_MODE_LO +: 2] == FM_SINGLE);
	assign prot_en       = cfg_q[CFG_PROT_EN];

	always_comb
	begin
		mode_d = MD_SINGLE;
		if (lpc_q[LPC_AUTO_DIS])
		begin
			unique case (lpc_q[LPC_MODE_LO +: 2])
				FM_SINGLE: mode_d = MD_SINGLE;
				FM_DUAL:   mode_d = MD_DUAL;
				FM_REPL:   mode_d = MD_REPL;
				FM_SECOND: mode_d = MD_SECOND;
			endcase
		end
		else if (rx_s2[0] && rx_s2[2] && freq_q >= DUAL_MIN_MHZ)
			mode_d = MD_DUAL;
		else if (rx_s2[0] && rx_s2[1])
			mode_d = MD_REPL;
		else if (rx_s2[1])
			mode_d = MD_SECOND;
		else
			mode_d = MD_SINGLE;
		unique case (mode_d)
			MD_DUAL: over_d = freq_q > DUAL_MAX_MHZ;
			MD_REPL: over_d = freq_q > REPL_MAX_MHZ;
			default: over_d = freq_q > SINGLE_MAX_MHZ;
		endcase
	end

	// all link outputs switch on the same edge
	always_ff @(posedge ref_clk_i)
	begin
		if (!nrst_i)
		begin
			mode_q          <= MD_SINGLE;
			over_q          <= 1'b0;
			tx0_en_o        <= 1'b0;
			tx1_en_o        <= 1'b0;
			bc1_en_o        <= 1'b0;
			pixel_split_o   <= 1'b0;
			tx_half_rate_o  <= 1'b0;
			prot_shared_o   <= 1'b0;
			prot_core1_en_o <= 1'b0;
			legacy_compat_o <= 1'b0;
		end
		else
		begin
			mode_q          <= mode_d;
			over_q          <= over_d;
			tx0_en_o        <= mode_d != MD_SECOND;
			tx1_en_o        <= mode_d != MD_SINGLE;
			bc1_en_o        <= !forced_single;
			pixel_split_o   <= mode_d == MD_DUAL;
			tx_half_rate_o  <= mode_d == MD_DUAL;
			prot_shared_o   <= prot_en && mode_d == MD_DUAL;
			prot_core1_en_o <= prot_en && mode_d == MD_REPL;
			legacy_compat_o <= freq_q < LEGACY_MAX_MHZ && (mode_d == MD_SINGLE || mode_d == MD_SECOND);
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		display_id_disable_o     <= nrst_i & ctl_q[CTL_DISP_ID_DIS];
		aux_audio_o              <= nrst_i & cfg_q[CFG_AUX_AUDIO];
		ext_override_o           <= nrst_i & cfg_q[CFG_EXT_OVR];
		cable_select_o           <= nrst_i & lpc_q[LPC_CABLE];
		remote_display_id_load_o <= nrst_i & cfg_q[CFG_REM_LOAD];
	end

endmodule // slm_top
